// ==== sim/testbench.sv ====
/*
  Self-checking bench for ubeos_core with a remote node model.
  Assumes OVS=4 and a sample tick every other clock.
*/
`timescale 1ns/10ps

module testbench;
  import ubeos_pkg::*;
  localparam int OVS = 4;
  localparam int BT  = 2 * OVS;
  logic clk, rst, wr, rd, tick, rxp, txp, start, brk, busy, full, fe, idl, bseen, irq;
  logic standby, cv, rd_seen;
  logic [7:0] addr, wd, rdata, cd, r;
  logic [9:0] txd, d;
  ubeos_format_s  fmt;
  ubeos_rx_word_s word;
  logic [21:0] reg_q[$], rx_q[$], tx_q[$];
  int bad_count, n_checks, icnt, len, e;

  ubeos_core #(.OVS(OVS)) u_dut (
    .ref_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .char_format_i(fmt),
    .rx_wakeup_standby_i(standby), .sample_tick_i(tick), .rx_pin_i(rxp),
    .tx_pin_o(txp), .tx_start_i(start), .tx_data_i(txd), .tx_break_i(brk),
    .tx_busy_o(busy), .rx_word_o(word), .rx_full_set_o(full),
    .framing_error_set_o(fe), .idle_flag_set_o(idl), .break_seen_o(bseen), .irq_o(irq));
  ubeos_remote_node #(.BT(BT)) u_node (
    .clk_i(clk), .line_i(txp), .line_o(rxp), .cap_valid_o(cv), .cap_data_o(cd));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {rst, wr, rd, tick, start, brk, standby, rd_seen} = 8'h80;
    {addr, wd, txd, fmt} = '0;
    {bad_count, n_checks, icnt} = '0;
  end
  always @(posedge clk) tick <= ~tick;

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic summarize;
    $display("checks=%0d bad=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [10:0] got, input logic [21:0] x);
    n_checks++;
    if ((got & x[21:11]) !== x[10:0]) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, x[10:0]);
    end
  endtask : chk

  task automatic take(input logic [10:0] got, ref logic [21:0] q[$]);
    chk(got, (q.size() != 0) ? q.pop_front() : {11'h7ff, 11'hx});
  endtask : take

  task automatic bits(input int n);
    repeat (n * BT) @(posedge clk);
  endtask : bits

  task automatic wr_reg(input logic [7:0] a, v);
    @(posedge clk);
    addr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, x, m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    reg_q.push_back({3'h0, m, 3'h0, x});
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg

  task automatic wait_free;
    bits(1);
    for (len = 0; busy !== 1'b0; len++) begin
      if (len > 400) begin
        bad_count++;
        summarize();
      end
      @(posedge clk);
    end
    bits(1);
  endtask : wait_free

  // results compared in arrival order against queued notes
  always @(posedge clk) begin
    if (rd_seen) take({3'h0, rdata}, reg_q);
    if (full) take(word, rx_q);
    if (cv) take({3'h0, cd}, tx_q);
    if (idl) icnt++;
    rd_seen <= rd;
  end

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    summarize();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    void'($urandom(32'h5e92));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_reg(8'h05, 8'h00, 8'hff);
    rd_reg(8'h10, 8'h00, 8'hff);
    wr_reg(8'h05, 8'h2f);
    rd_reg(8'h05, 8'h2e, 8'hbf);
    wr_reg(8'h33, 8'hff);
    rd_reg(8'h33, 8'h00, 8'hff);
    wr_reg(8'h05, 8'hc0);
    for (int f = 0; f < 3; f++) begin
      for (int m = 0; m < 2; m++) begin
        d = 10'($urandom) & ((10'h1 << (8 + f)) - 10'h1);
        fmt <= {f == 2, f == 1, 2'b00};
        wr_reg(8'h05, {2'b11, m[0], 5'h00});
        rx_q.push_back({11'h7ff, d, 1'b0});
        fork
          u_node.send(d, 8 + f, m[0]);
          begin
            bits(3);
            rd_reg(8'h05, 8'h41, 8'h41);
          end
        join
        bits(12);
        rd_reg(8'h05, 8'h00, 8'h01);
      end
    end
    fmt <= '0;
    wr_reg(8'h05, 8'h10);
    u_node.inv = 1'b1;
    u_node.hold(1'b1, 2);
    wr_reg(8'h05, 8'hd0);
    rd_reg(8'h05, 8'h00, 8'h40);
    d = 10'($urandom) & 10'h0ff;
    rx_q.push_back({11'h7ff, d, 1'b0});
    u_node.send(d, 8, 1'b0);
    rd_reg(8'h05, 8'h40, 8'h40);
    wr_reg(8'h05, 8'hc0);
    u_node.inv = 1'b0;
    u_node.hold(1'b1, 14);
    rx_q.push_back({11'h7ff, 11'h001});
    u_node.hold(1'b0, 12);
    u_node.hold(1'b1, 14);
    rd_reg(8'h05, 8'h00, 8'h80);
    standby <= 1'b1;
    wr_reg(8'h10, 8'h80);
    for (int w = 0; w < 2; w++) begin
      wr_reg(8'h05, {4'hc, w[0], 3'h2});
      e = icnt;
      u_node.hold(1'b0, 12);
      u_node.hold(1'b1, 14);
      chk({10'h0, irq}, {11'h7ff, 11'h001});
      chk(11'(icnt - e), {11'h7ff, 10'h0, w[0]});
      rd_reg(8'h05, 8'h80, 8'h80);
      wr_reg(8'h05, 8'h82);
      bits(1);
      chk({10'h0, irq}, {11'h7ff, 11'h000});
    end
    standby <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      wr_reg(8'h05, {2'b00, m[0], 5'h00});
      d = 10'($urandom);
      for (int i = 0; i < 8; i++) r[i] = m ? d[7-i] : d[i];
      tx_q.push_back({11'h7ff, 3'h0, r});
      txd <= d;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      bits(2);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      wait_free();
    end
    for (int l = 0; l < 2; l++) begin
      wr_reg(8'h05, {5'h00, l[0], 2'b00});
      brk <= 1'b1;
      @(posedge clk);
      brk <= 1'b0;
      repeat (2) @(posedge clk);
      for (len = 0; txp === 1'b0 && len < 200; len++) @(posedge clk);
      e = (l ? 13 : 10) * BT;
      chk(11'((len >= e - 2 && len <= e + 1) ? e : len), {11'h7ff, 11'(e)});
      wait_free();
    end
    bits(2);
    bad_count += reg_q.size() + rx_q.size() + tx_q.size();
    summarize();
  end
endmodule : testbench

// ==== sim/ubeos_core_monitor.sv ====
/*
  Port-level checker for ubeos_core, bound to every instance.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/10ps

module ubeos_core_monitor
  import ubeos_pkg::*;
#(
  parameter int OVS = 16
) (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  // register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_rdata_o,
  // transmit
  input  wire logic       tx_start_i,
  input  wire logic       tx_break_i,
  input  wire logic       tx_busy_o,
  input  wire logic       tx_pin_o,
  // receive
  input  wire logic       rx_full_set_o,
  input  wire logic       framing_error_set_o,
  input  wire logic       break_seen_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // ************************************************************
  // assertions
  // ************************************************************
  a_read_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside a read reply");
  a_unmapped_read: assert property (($past(reg_rd_i) && $past(reg_addr_i) != UBEOS_SS2_OFFSET
    && $past(reg_addr_i) != UBEOS_IRQ_MASK_OFFSET) |-> reg_rdata_o == 8'h00)
    else $error("unmapped read returned data");
  a_mask_spare: assert property (($past(reg_rd_i) && $past(reg_addr_i) == 8'h10)
    |-> reg_rdata_o[5:0] == 6'h00)
    else $error("spare mask bits read nonzero");
  a_tx_launch: assert property ((!tx_busy_o && (tx_start_i || tx_break_i))
    |=> tx_busy_o ##1 !tx_pin_o)
    else $error("transmit did not start low");
  a_tx_idle_high: assert property ((!tx_busy_o && !$past(tx_busy_o)) |-> tx_pin_o)
    else $error("transmit pin low while idle");
  a_busy_min: assert property ($rose(tx_busy_o) |-> tx_busy_o[*4])
    else $error("transmitter busy too short");
  a_fe_with_full: assert property (framing_error_set_o |-> rx_full_set_o)
    else $error("framing error without receive full");
  a_full_pulse: assert property (rx_full_set_o |=> !rx_full_set_o)
    else $error("receive full pulse too long");
  a_break_once: assert property (break_seen_o |=> !break_seen_o)
    else $error("break seen more than once");

  c_rx_frame: cover property (rx_full_set_o);
  c_break: cover property (break_seen_o);
  c_tx: cover property ($rose(tx_busy_o));
endmodule : ubeos_core_monitor

bind ubeos_core ubeos_core_monitor #(.OVS(OVS)) u_mon (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .tx_start_i(tx_start_i),
  .tx_break_i(tx_break_i), .tx_busy_o(tx_busy_o), .tx_pin_o(tx_pin_o),
  .rx_full_set_o(rx_full_set_o), .framing_error_set_o(framing_error_set_o),
  .break_seen_o(break_seen_o));

// ==== sim/ubeos_remote_node.sv ====
/*
  Behavioural far-end serial node: sends frames and breaks, captures
  8-bit frames LSB first. Assumes a bit time of BT clock cycles.
*/
`timescale 1ns/10ps

module ubeos_remote_node #(
  parameter int BT = 8
) (
  // clock
  input  wire logic       clk_i,
  // serial lines
  input  wire logic       line_i,
  output logic            line_o,
  // captured frame
  output logic            cap_valid_o,
  output logic [7:0]      cap_data_o
);
  logic       inv;
  logic [7:0] c;

  initial begin
    inv = 1'b0;
    line_o = 1'b1;
    cap_valid_o = 1'b0;
    cap_data_o = 8'h00;
  end

  // ************************************************************
  // sending
  // ************************************************************
  task automatic hold(input logic v, input int nbits);
    line_o <= v ^ inv;
    repeat (nbits * BT) @(posedge clk_i);
  endtask : hold

  task automatic send(input logic [9:0] d, input int nb, input logic msb);
    hold(1'b0, 1);
    for (int i = 0; i < nb; i++) hold(msb ? d[nb-1-i] : d[i], 1);
    hold(1'b1, 2);
  endtask : send

  // ************************************************************
  // capture, mid-bit sampling; low stop means break, not reported
  // ************************************************************
  always begin
    @(negedge line_i);
    repeat (BT / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BT) @(posedge clk_i);
      c[i] = line_i;
    end
    repeat (BT) @(posedge clk_i);
    if (line_i) begin
      cap_data_o <= c;
      cap_valid_o <= 1'b1;
      @(posedge clk_i);
      cap_valid_o <= 1'b0;
    end
  end
endmodule : ubeos_remote_node

// ==== verilog/ubeos_core.sv ====
/*
  Second status/control register of a serial receiver/transmitter with a
  small receiver, transmitter, break and idle detectors and interrupt.
  Assumes sample_tick_i pulses OVS times per bit and that the character
  format inputs stay stable while a frame is in flight.
*/
`timescale 1ns/10ps

// Behaviour
// - break flag sets on detected break while enabled; write one clears it
// - edge flag sets on falling, or rising when inverted, receive edge; write one clears
// - bit-order control reverses data bits only; parity, start, stop stay put
// - normal order sends bit0 first and stores first received bit as bit0
// - reversed order starts at top data bit chosen by length and parity
// - receive inversion applies to data, start, stop, break and idle
// - idle-wake control clear: no idle flag for idle during wake-up standby
// - long break enable blocks framing error and raises break threshold
// - normal break threshold is 10 bits for eight-bit; long adds one bit time, two in ten-bit format
// - receiver-active bit is read-only, break and edge flags write-one-clear, others read/write, reset clears all
// - receiver-active sets on valid start bit, clears on idle line
// - idle-wake control set: idle during wake-up standby sets idle flag
// - long break detects at 11 bits in eight-bit format, no framing error or receive-full
// - transmitted break is 10 bits, or 13 with long-break transmit, in eight-bit format
module ubeos_core #(
  parameter int OVS = 16
) (
  // clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    sys_rst_i,
  // register port
  input  wire logic [7:0]              reg_addr_i,
  input  wire logic [7:0]              reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  output logic      [7:0]              reg_rdata_o,
  // format and mode from neighbouring registers
  input  wire ubeos_pkg::ubeos_format_s char_format_i,
  input  wire logic                    rx_wakeup_standby_i,
  input  wire logic                    sample_tick_i,
  // serial line
  input  wire logic                    rx_pin_i,
  output logic                         tx_pin_o,
  // transmit requests
  input  wire logic                    tx_start_i,
  input  wire logic [9:0]              tx_data_i,
  input  wire logic                    tx_break_i,
  output logic                         tx_busy_o,
  // receive results for neighbouring registers
  output ubeos_pkg::ubeos_rx_word_s    rx_word_o,
  output logic                         rx_full_set_o,
  output logic                         framing_error_set_o,
  output logic                         idle_flag_set_o,
  output logic                         break_seen_o,
  // interrupt
  output logic                         irq_o
);
  import ubeos_pkg::*;

  localparam int SW = $clog2(OVS);
  localparam logic [SW-1:0] SUB_MID  = SW'(OVS / 2 - 1);
  localparam logic [SW-1:0] SUB_LAST = SW'(OVS - 1);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [3:0] frame_bits(input ubeos_format_s f);
    if (f.ten_bit_char) begin
      frame_bits = UBEOS_BITS_TEN;
    end else if (f.nine_bit_char) begin
      frame_bits = UBEOS_BITS_NINE;
    end else begin
      frame_bits = UBEOS_BITS_EIGHT;
    end
  endfunction : frame_bits

  function automatic logic [1:0] fmt_index(input ubeos_format_s f);
    fmt_index = f.ten_bit_char ? 2'h2 : (f.nine_bit_char ? 2'h1 : 2'h0);
  endfunction : fmt_index

  function automatic logic [9:0] low_mask(input logic [3:0] n);
    low_mask = 10'h3ff >> (4'ha - n);
  endfunction : low_mask

  // reverse the low d bits, leave parity and upper bits in place
  function automatic logic [9:0] rev_data(input logic [9:0] w, input logic [3:0] d);
    logic [9:0] r;
    r = w;
    for (int i = 0; i < 10; i++) begin
      if (4'(i) < d) begin
        r[i] = w[4'(d - 4'(i) - 4'h1)];
      end
    end
    rev_data = r;
  endfunction : rev_data

  // ************************************************************
  // control register and derived format
  // ************************************************************
  logic       brk_flag_reg;
  logic       edge_flag_reg;
  logic [5:1] ctrl_reg;
  logic       raf_reg;
  logic [7:6] mask_reg;
  logic       wr_ss2;
  logic       wr_mask;
  logic       reverse_bit_order;
  logic       long_break_detect_enable;
  logic [3:0] nbits;
  logic [3:0] dbits;
  logic [1:0] fidx;
  logic       rx_level;
  logic       rx_edge;

  assign wr_ss2  = reg_wr_i && (reg_addr_i == UBEOS_SS2_OFFSET);
  assign wr_mask = reg_wr_i && (reg_addr_i == UBEOS_IRQ_MASK_OFFSET);
  assign reverse_bit_order    = ctrl_reg[UBEOS_REVERSE_BIT_ORDER_BIT];
  assign long_break_detect_enable   = ctrl_reg[UBEOS_LONG_BREAK_DETECT_ENABLE_BIT];
  assign nbits   = frame_bits(char_format_i);
  assign dbits   = nbits - {3'h0, char_format_i.parity_enable};
  assign fidx    = fmt_index(char_format_i);

  ubeos_rx_front u_rx_front (
    .ref_clk_i     (ref_clk_i),
    .sys_rst_i     (sys_rst_i),
    .rx_pin_i      (rx_pin_i),
    .invert_i      (ctrl_reg[UBEOS_RX_POLARITY_INVERT_BIT]),
    .rx_level_o    (rx_level),
    .active_edge_o (rx_edge)
  );

  // ************************************************************
  // line run counter: break and idle detection
  // ************************************************************
  logic          prev_level_reg;
  logic [SW-1:0] run_sub_reg;
  logic [4:0]    run_bits_reg;
  logic          run_armed_reg;
  logic [4:0]    brk_thr;
  logic [4:0]    idle_len;
  logic          brk_evt;
  logic          idle_evt;

  assign brk_thr  = long_break_detect_enable ? UBEOS_RX_BRK_LONG[fidx] : UBEOS_RX_BRK_NORM[fidx];
  assign idle_len = {1'b0, nbits} + UBEOS_FRAME_OVERHEAD;
  assign brk_evt  = run_armed_reg && !rx_level && (run_bits_reg == brk_thr);
  assign idle_evt = run_armed_reg && rx_level && (run_bits_reg == idle_len);

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      prev_level_reg <= 1'b1;
      run_sub_reg    <= '0;
      run_bits_reg   <= '0;
      run_armed_reg  <= 1'b0;
    end else begin
      prev_level_reg <= rx_level;
      if (rx_level != prev_level_reg) begin
        run_sub_reg   <= '0;
        run_bits_reg  <= '0;
        run_armed_reg <= 1'b1;
      end else begin
        if (brk_evt || idle_evt) begin
          run_armed_reg <= 1'b0;
        end
        if (sample_tick_i) begin
          run_sub_reg <= (run_sub_reg == SUB_LAST) ? '0 : run_sub_reg + 1'b1;
          if (run_sub_reg == SUB_LAST && run_bits_reg != 5'h1f) begin
            run_bits_reg <= run_bits_reg + 5'h01;
          end
        end
      end
    end
  end

  // ************************************************************
  // receiver
  // ************************************************************
  ubeos_rx_state_e rx_state_reg;
  logic [SW-1:0]   rx_sub_reg;
  logic [3:0]      rx_bit_reg;
  logic [9:0]      rx_shift_reg;
  logic            rx_bit_end;
  logic            start_ok;
  logic            stop_done;
  logic [9:0]      rx_aligned;

  assign rx_bit_end = sample_tick_i && (rx_sub_reg == SUB_LAST);
  assign start_ok   = (rx_state_reg == RX_START) && sample_tick_i &&
                      (rx_sub_reg == SUB_MID) && !rx_level;
  assign stop_done  = (rx_state_reg == RX_STOP) && rx_bit_end;
  assign rx_aligned = rx_shift_reg >> (4'ha - nbits);

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rx_state_reg <= RX_IDLE;
      rx_sub_reg   <= '0;
      rx_bit_reg   <= '0;
      rx_shift_reg <= '0;
    end else begin
      case (rx_state_reg)
        RX_IDLE: begin
          rx_sub_reg <= '0;
          if (!rx_level) begin
            rx_state_reg <= RX_START;
          end
        end
        RX_START: begin
          if (sample_tick_i) begin
            if (rx_sub_reg == SUB_MID) begin
              rx_sub_reg   <= '0;
              rx_bit_reg   <= '0;
              rx_state_reg <= rx_level ? RX_IDLE : RX_DATA;
            end else begin
              rx_sub_reg <= rx_sub_reg + 1'b1;
            end
          end
        end
        RX_DATA: begin
          if (sample_tick_i) begin
            rx_sub_reg <= rx_sub_reg + 1'b1;
          end
          if (rx_bit_end) begin
            rx_shift_reg <= {rx_level, rx_shift_reg[9:1]};
            rx_bit_reg   <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == nbits - 4'h1) begin
              rx_state_reg <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (sample_tick_i) begin
            rx_sub_reg <= rx_sub_reg + 1'b1;
          end
          if (rx_bit_end) begin
            // a low stop bit means a break may follow; wait for mark first
            rx_state_reg <= rx_level ? RX_IDLE : RX_WAIT_HIGH;
          end
        end
        default: begin
          if (rx_level) begin
            rx_state_reg <= RX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rx_word_o           <= '0;
      rx_full_set_o       <= 1'b0;
      framing_error_set_o <= 1'b0;
    end else begin
      rx_full_set_o       <= stop_done && !long_break_detect_enable;
      framing_error_set_o <= stop_done && !long_break_detect_enable && !rx_level;
      if (stop_done && !long_break_detect_enable) begin
        rx_word_o.data          <= reverse_bit_order ? rev_data(rx_aligned, dbits) : rx_aligned;
        rx_word_o.framing_error <= !rx_level;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      idle_flag_set_o <= 1'b0;
      break_seen_o    <= 1'b0;
    end else begin
      idle_flag_set_o <= idle_evt && (!rx_wakeup_standby_i ||
                         ctrl_reg[UBEOS_WAKE_IDLE_SETS_FLAG_BIT]);
      break_seen_o    <= brk_evt;
    end
  end

  // ************************************************************
  // transmitter
  // ************************************************************
  ubeos_tx_state_e tx_state_reg;
  logic [SW-1:0]   tx_sub_reg;
  logic [4:0]      tx_bit_reg;
  logic [10:0]     tx_shift_reg;
  logic [9:0]      tx_payload;
  logic [9:0]      tx_ordered;
  logic            tx_parity;
  logic            tx_bit_end;
  logic [4:0]      tx_brk_len;

  assign tx_bit_end = sample_tick_i && (tx_sub_reg == SUB_LAST);
  assign tx_brk_len = ctrl_reg[UBEOS_LONG_BREAK_TRANSMIT_BIT] ? UBEOS_TX_BRK_LONG[fidx] :
                      UBEOS_TX_BRK_NORM[fidx];
  assign tx_parity  = ^(tx_data_i & low_mask(dbits)) ^ char_format_i.parity_odd;

  always_comb begin
    tx_ordered = tx_data_i & low_mask(dbits);
    if (reverse_bit_order) begin
      tx_ordered = rev_data(tx_ordered, dbits);
    end
    tx_payload = tx_ordered;
    if (char_format_i.parity_enable) begin
      tx_payload[dbits] = tx_parity;
    end
    tx_payload = tx_payload | ~low_mask(nbits);
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      tx_state_reg <= TX_IDLE;
      tx_sub_reg   <= '0;
      tx_bit_reg   <= '0;
      tx_shift_reg <= '1;
      tx_pin_o     <= 1'b1;
      tx_busy_o    <= 1'b0;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          tx_sub_reg <= '0;
          tx_bit_reg <= '0;
          tx_pin_o   <= 1'b1;
          if (tx_break_i) begin
            tx_state_reg <= TX_BREAK;
            tx_busy_o    <= 1'b1;
          end else if (tx_start_i) begin
            tx_shift_reg <= {tx_payload, 1'b0};
            tx_state_reg <= TX_FRAME;
            tx_busy_o    <= 1'b1;
          end
        end
        TX_FRAME: begin
          tx_pin_o <= tx_shift_reg[0];
          if (sample_tick_i) begin
            tx_sub_reg <= tx_sub_reg + 1'b1;
          end
          if (tx_bit_end) begin
            tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
            tx_bit_reg   <= tx_bit_reg + 5'h01;
            if (tx_bit_reg == {1'b0, nbits} + 5'h01) begin
              tx_state_reg <= TX_IDLE;
              tx_busy_o    <= 1'b0;
            end
          end
        end
        default: begin
          tx_pin_o <= 1'b0;
          if (sample_tick_i) begin
            tx_sub_reg <= tx_sub_reg + 1'b1;
          end
          if (tx_bit_end) begin
            tx_bit_reg <= tx_bit_reg + 5'h01;
            if (tx_bit_reg == tx_brk_len - 5'h01) begin
              tx_state_reg <= TX_IDLE;
              tx_busy_o    <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // ************************************************************
  // register file and interrupt
  // ************************************************************
  // set wins over a simultaneous write-one clear
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      brk_flag_reg  <= UBEOS_SS2_RESET[UBEOS_BRK_FLAG_BIT];
      edge_flag_reg <= UBEOS_SS2_RESET[UBEOS_EDGE_FLAG_BIT];
    end else begin
      brk_flag_reg  <= (brk_flag_reg & ~(wr_ss2 & reg_wdata_i[UBEOS_BRK_FLAG_BIT])) |
                       (brk_evt & long_break_detect_enable);
      edge_flag_reg <= (edge_flag_reg & ~(wr_ss2 & reg_wdata_i[UBEOS_EDGE_FLAG_BIT])) |
                       rx_edge;
    end
  end

  // bit order and idle-wake are live; software must change them only when idle
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= UBEOS_SS2_RESET[5:1];
    end else if (wr_ss2) begin
      ctrl_reg <= reg_wdata_i[5:1];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      raf_reg <= UBEOS_SS2_RESET[UBEOS_RAF_BIT];
    end else begin
      raf_reg <= (raf_reg & ~idle_evt) | start_ok;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      mask_reg <= UBEOS_IRQ_MASK_RESET[7:6];
    end else if (wr_mask) begin
      mask_reg <= reg_wdata_i[7:6];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
      irq_o       <= 1'b0;
    end else begin
      irq_o <= |({brk_flag_reg, edge_flag_reg} & mask_reg);
      if (reg_rd_i && reg_addr_i == UBEOS_SS2_OFFSET) begin
        reg_rdata_o <= {brk_flag_reg, edge_flag_reg, ctrl_reg, raf_reg};
      end else if (reg_rd_i && reg_addr_i == UBEOS_IRQ_MASK_OFFSET) begin
        reg_rdata_o <= {mask_reg, 6'h00};
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

endmodule : ubeos_core

// ==== verilog/ubeos_pkg.sv ====
/*
  Shared constants, field layout, carriers and state enums for the
  break, edge, bit-order and status block of a serial receiver/transmitter.
  Assumes the including modules import the whole package.
*/
package ubeos_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] UBEOS_SS2_OFFSET      = 8'h05;
  localparam logic [7:0] UBEOS_IRQ_MASK_OFFSET = 8'h10;
  localparam logic [7:0] UBEOS_SS2_RESET       = 8'h00;
  localparam logic [7:0] UBEOS_IRQ_MASK_RESET  = 8'h00;

  // ************************************************************
  // field positions of serial_status_two
  // ************************************************************
  localparam int UBEOS_BRK_FLAG_BIT  = 7;
  localparam int UBEOS_EDGE_FLAG_BIT = 6;
  localparam int UBEOS_REVERSE_BIT_ORDER_BIT      = 5;
  localparam int UBEOS_RX_POLARITY_INVERT_BIT     = 4;
  localparam int UBEOS_WAKE_IDLE_SETS_FLAG_BIT     = 3;
  localparam int UBEOS_LONG_BREAK_TRANSMIT_BIT     = 2;
  localparam int UBEOS_LONG_BREAK_DETECT_ENABLE_BIT     = 1;
  localparam int UBEOS_RAF_BIT       = 0;

  // ************************************************************
  // frame and timing counts, in bit times
  // ************************************************************
  localparam int         UBEOS_OVERSAMPLE = 16;
  localparam logic [3:0] UBEOS_BITS_EIGHT = 4'h8;
  localparam logic [3:0] UBEOS_BITS_NINE  = 4'h9;
  localparam logic [3:0] UBEOS_BITS_TEN   = 4'ha;
  localparam logic [4:0] UBEOS_FRAME_OVERHEAD = 5'h02;
  // indexed by format: 0 eight-bit, 1 nine-bit, 2 ten-bit
  localparam logic [2:0][4:0] UBEOS_RX_BRK_NORM = {5'h0c, 5'h0b, 5'h0a};
  localparam logic [2:0][4:0] UBEOS_RX_BRK_LONG = {5'h0e, 5'h0c, 5'h0b};
  localparam logic [2:0][4:0] UBEOS_TX_BRK_NORM = {5'h0c, 5'h0b, 5'h0a};
  localparam logic [2:0][4:0] UBEOS_TX_BRK_LONG = {5'h0f, 5'h0e, 5'h0d};

  // ************************************************************
  // carriers and states
  // ************************************************************
  typedef struct packed {
    logic ten_bit_char;
    logic nine_bit_char;
    logic parity_enable;
    logic parity_odd;
  } ubeos_format_s;

  typedef struct packed {
    logic [9:0] data;
    logic       framing_error;
  } ubeos_rx_word_s;

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_WAIT_HIGH} ubeos_rx_state_e;
  typedef enum logic [1:0] {TX_IDLE, TX_FRAME, TX_BREAK} ubeos_tx_state_e;

endpackage : ubeos_pkg

// ==== verilog/ubeos_rx_front.sv ====
/*
  Receive pin front end: two-stage synchroniser, polarity inversion and
  active-edge pulse. Assumes the pin is idle high on the wire.
*/
`timescale 1ns/10ps

module ubeos_rx_front (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  // pin and control
  input  wire logic rx_pin_i,
  input  wire logic invert_i,
  // conditioned outputs
  output logic      rx_level_o,
  output logic      active_edge_o
);

  logic sync1_reg;
  logic sync2_reg;
  logic level_reg;
  logic edge_reg;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= rx_pin_i;
      sync2_reg <= sync1_reg;
    end
  end

  // inversion after the synchroniser; a live change of invert_i looks like an edge
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      level_reg <= 1'b1;
      edge_reg  <= 1'b0;
    end else begin
      level_reg <= sync2_reg ^ invert_i;
      edge_reg  <= level_reg & ~(sync2_reg ^ invert_i);
    end
  end

  assign rx_level_o    = level_reg;
  assign active_edge_o = edge_reg;

endmodule : ubeos_rx_front
